// file: hw/e1m_pkg.sv
// Purpose: Constants shared by the receive error and alarm monitor
// Assumes: One system clock; register port driven by the serial decoder
// Notes:   Offsets are register indices on the internal register port
`default_nettype none

package e1m_pkg;

	////////////////////////////////////////////////////////////////////
	// Register port
	localparam int unsigned ADDR_W = 4;
	localparam int unsigned DATA_W = 8;

	localparam logic [3:0] OFS_COMMON_CTRL = 4'h0;
	localparam logic [3:0] OFS_TX_CTRL     = 4'h1;
	localparam logic [3:0] OFS_RX_CTRL     = 4'h2;
	localparam logic [3:0] OFS_TX_IDLE     = 4'h3;
	localparam logic [3:0] OFS_TX_EXTRA    = 4'h4;
	localparam logic [3:0] OFS_RX_STATUS   = 4'h5;
	localparam logic [3:0] OFS_RX_IRQ_MASK = 4'h6;
	localparam logic [3:0] OFS_LINE_VIOL   = 4'h7;
	localparam logic [3:0] OFS_CRC_ERR     = 4'h8;
	localparam logic [3:0] OFS_FRAME_ERR   = 4'h9;

	////////////////////////////////////////////////////////////////////
	// Reset values
	localparam logic [7:0] RST_REG   = 8'h00;
	localparam logic [7:0] RST_COUNT = 8'h00;

	////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int unsigned COMMON_TX_HDB3 = 5;
	localparam int unsigned COMMON_RX_HDB3 = 4;
	localparam int unsigned COMMON_TX_CRC4 = 3;
	localparam int unsigned COMMON_RX_CRC4 = 2;
	localparam int unsigned CAS_DISABLE    = 5;
	localparam int unsigned IDLE_TX_RA     = 5;
	localparam int unsigned EXTRA_TX_DMA   = 2;
	localparam int unsigned STAT_RA        = 7;
	localparam int unsigned STAT_DMA       = 6;
	localparam int unsigned STAT_LOS       = 1;
	localparam int unsigned STAT_SAT       = 0;
	localparam logic [7:0]  STAT_USED      = 8'hC3;

	////////////////////////////////////////////////////////////////////
	// Counts
	localparam logic [7:0] COUNT_MAX     = 8'hFF;
	localparam logic [5:0] ZERO_RUN      = 6'h20;
	localparam logic [1:0] ALARM_RUN     = 2'h3;

	// Pin sample vector positions
	localparam int unsigned PIN_N        = 8;
	localparam int unsigned PIN_POS      = 0;
	localparam int unsigned PIN_NEG      = 1;
	localparam int unsigned PIN_SEL      = 2;
	localparam int unsigned PIN_RALM     = 3;
	localparam int unsigned PIN_DALM     = 4;
	localparam int unsigned PIN_FMT      = 5;
	localparam int unsigned PIN_CRC      = 6;
	localparam int unsigned PIN_CAS      = 7;

endpackage : e1m_pkg

`default_nettype wire

// file: hw/e1m_sat_counter.sv
// Purpose: Presettable 8-bit saturating error counter
// Assumes: Not cleared by the chip reset, only by hardware-mode clear
// Notes:   Preset wins over a same-cycle increment
`default_nettype none

module e1m_sat_counter (
	input  wire logic       sys_clk,
	input  wire logic       clear,
	input  wire logic       load,
	input  wire logic [7:0] loadValue,
	input  wire logic       inc,
	output logic      [7:0] count,
	output logic            satHit
);

	logic [7:0] count_q;

	////////////////////////////////////////////////////////////////////
	// Counter, no async reset by design
	always_ff @(posedge sys_clk) begin
		if (clear) begin
			count_q <= e1m_pkg::RST_COUNT;
		end else if (load) begin
			count_q <= loadValue;
		end else if (inc && count_q != e1m_pkg::COUNT_MAX) begin
			count_q <= count_q + 8'h01;
		end
	end

	assign count  = count_q;
	// Error seen while pinned at full scale
	assign satHit = inc && !load && !clear &&
		count_q == e1m_pkg::COUNT_MAX;

endmodule // e1m_sat_counter

`default_nettype wire

// file: hw/e1m_rx_alarm_monitor.sv
// Purpose: Receive error counters, alarm outputs, status and strapping
// Assumes: Framer events are one-cycle pulses on sys_clk
// Notes:   Pins pass a two-flop synchroniser before use
`default_nettype none

module e1m_rx_alarm_monitor (
	input  wire logic       sys_clk,
	input  wire logic       nrst,
	// Line and strap pins
	input  wire logic       line_in_positive,
	input  wire logic       line_in_negative,
	input  wire logic       serial_port_select,
	input  wire logic       tx_remote_alarm_strap,
	input  wire logic       tx_distant_mf_alarm_strap,
	input  wire logic       dataFormatStrap,
	input  wire logic       crc4Strap,
	input  wire logic       casDisableStrap,
	// Receive framer events
	input  wire logic       lineBitStrobe,
	input  wire logic       violationEvt,
	input  wire logic       hdb3CodeWord,
	input  wire logic       crcErrEvt,
	input  wire logic       fasErrEvt,
	input  wire logic       casMfErrEvt,
	input  wire logic       casIntervalEnd,
	input  wire logic       syncSearch,
	input  wire logic       nonAlignStrobe,
	input  wire logic       nonAlignBit3,
	input  wire logic       frame0Ts16Strobe,
	input  wire logic       frame0Ts16Bit6,
	// Register port from the serial decoder
	input  wire logic [3:0] regAddr,
	input  wire logic       regWrEn,
	input  wire logic [7:0] regWrData,
	input  wire logic       regRdEn,
	input  wire logic       regBurst,
	output logic      [7:0] regRdData,
	// Alarm outputs
	output logic            loss_of_sync_out,
	output logic            remote_alarm_out,
	output logic            distant_mf_alarm_out,
	output logic            carrier_loss_out,
	output logic            violation_pulse_out,
	output logic            frame_error_out,
	output logic            irqOut,
	// Effective configuration
	output logic            hwMode,
	output logic            txRemoteAlarmEn,
	output logic            txDistantMfAlarmEn,
	output logic            txHdb3En,
	output logic            rxHdb3En,
	output logic            txCrc4En,
	output logic            rxCrc4En,
	output logic            txCasEn,
	output logic            rxCasEn
);

	////////////////////////////////////////////////////////////////////
	// Pin synchroniser
	logic [7:0] pinRaw;
	logic [7:0] pinMeta_q;
	logic [7:0] pinSync_q;

	assign pinRaw = {casDisableStrap, crc4Strap, dataFormatStrap,
		tx_distant_mf_alarm_strap, tx_remote_alarm_strap,
		serial_port_select, line_in_negative, line_in_positive};

	// Select reads high after reset so the port starts enabled
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			pinMeta_q <= 8'h04;
			pinSync_q <= 8'h04;
		end else begin
			pinMeta_q <= pinRaw;
			pinSync_q <= pinMeta_q;
		end
	end

	logic hwMode_q;
	logic posIn;
	logic negIn;
	assign posIn = pinSync_q[e1m_pkg::PIN_POS];
	assign negIn = pinSync_q[e1m_pkg::PIN_NEG];

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			hwMode_q <= 1'b0;
		end else begin
			hwMode_q <= !pinSync_q[e1m_pkg::PIN_SEL];
		end
	end
	assign hwMode = hwMode_q;

	////////////////////////////////////////////////////////////////////
	// Register decode
	function automatic logic hit(input logic [3:0] a, input logic [3:0] o);
		hit = (a == o);
	endfunction

	logic wrOk;
	logic rdDirect;
	assign wrOk     = regWrEn && !hwMode_q;
	assign rdDirect = regRdEn && !regBurst && !hwMode_q &&
		hit(regAddr, e1m_pkg::OFS_RX_STATUS);

	////////////////////////////////////////////////////////////////////
	// Control registers; strapped bits follow pins in hardware mode
	logic [7:0] commonCtrl_q;
	logic [7:0] txCtrl_q;
	logic [7:0] rxCtrl_q;
	logic [7:0] txIdle_q;
	logic [7:0] txExtra_q;
	logic [7:0] mask_q;
	logic       fmt;
	logic       crc;
	logic       casOff;

	assign fmt    = pinSync_q[e1m_pkg::PIN_FMT];
	assign crc    = pinSync_q[e1m_pkg::PIN_CRC];
	assign casOff = pinSync_q[e1m_pkg::PIN_CAS];

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			commonCtrl_q <= e1m_pkg::RST_REG;
		end else if (hwMode_q) begin
			commonCtrl_q <= e1m_pkg::RST_REG;
			commonCtrl_q[e1m_pkg::COMMON_TX_HDB3] <= fmt;
			commonCtrl_q[e1m_pkg::COMMON_RX_HDB3] <= fmt;
			commonCtrl_q[e1m_pkg::COMMON_TX_CRC4] <= crc;
			commonCtrl_q[e1m_pkg::COMMON_RX_CRC4] <= crc;
		end else if (wrOk && hit(regAddr, e1m_pkg::OFS_COMMON_CTRL)) begin
			commonCtrl_q <= regWrData;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			txCtrl_q <= e1m_pkg::RST_REG;
			rxCtrl_q <= e1m_pkg::RST_REG;
		end else if (hwMode_q) begin
			txCtrl_q <= e1m_pkg::RST_REG;
			rxCtrl_q <= e1m_pkg::RST_REG;
			txCtrl_q[e1m_pkg::CAS_DISABLE] <= casOff;
			rxCtrl_q[e1m_pkg::CAS_DISABLE] <= casOff;
		end else begin
			if (wrOk && hit(regAddr, e1m_pkg::OFS_TX_CTRL)) begin
				txCtrl_q <= regWrData;
			end
			if (wrOk && hit(regAddr, e1m_pkg::OFS_RX_CTRL)) begin
				rxCtrl_q <= regWrData;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			txIdle_q  <= e1m_pkg::RST_REG;
			txExtra_q <= e1m_pkg::RST_REG;
		end else if (hwMode_q) begin
			txIdle_q  <= e1m_pkg::RST_REG;
			txExtra_q <= e1m_pkg::RST_REG;
			txIdle_q[e1m_pkg::IDLE_TX_RA] <=
				pinSync_q[e1m_pkg::PIN_RALM];
			txExtra_q[e1m_pkg::EXTRA_TX_DMA] <=
				pinSync_q[e1m_pkg::PIN_DALM];
		end else begin
			if (wrOk && hit(regAddr, e1m_pkg::OFS_TX_IDLE)) begin
				txIdle_q <= regWrData;
			end
			if (wrOk && hit(regAddr, e1m_pkg::OFS_TX_EXTRA)) begin
				txExtra_q <= regWrData;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			mask_q <= e1m_pkg::RST_REG;
		end else if (hwMode_q) begin
			mask_q <= e1m_pkg::RST_REG;
		end else if (wrOk && hit(regAddr, e1m_pkg::OFS_RX_IRQ_MASK)) begin
			mask_q <= regWrData;
		end
	end

	assign txRemoteAlarmEn    = txIdle_q[e1m_pkg::IDLE_TX_RA];
	assign txDistantMfAlarmEn = txExtra_q[e1m_pkg::EXTRA_TX_DMA];
	assign txHdb3En           = commonCtrl_q[e1m_pkg::COMMON_TX_HDB3];
	assign rxHdb3En           = commonCtrl_q[e1m_pkg::COMMON_RX_HDB3];
	assign txCrc4En           = commonCtrl_q[e1m_pkg::COMMON_TX_CRC4];
	assign rxCrc4En           = commonCtrl_q[e1m_pkg::COMMON_RX_CRC4];
	assign txCasEn            = !txCtrl_q[e1m_pkg::CAS_DISABLE];
	assign rxCasEn            = !rxCtrl_q[e1m_pkg::CAS_DISABLE];

	////////////////////////////////////////////////////////////////////
	// Loss of sync; forced while reset is low
	logic los_q;
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			los_q <= 1'b1;
		end else begin
			los_q <= syncSearch;
		end
	end
	assign loss_of_sync_out = los_q;

	////////////////////////////////////////////////////////////////////
	// Error counters
	logic       violCount;
	logic       crcCount;
	logic       fasCount;
	logic [7:0] violCnt;
	logic [7:0] crcCnt;
	logic [7:0] fasCnt;
	logic [2:0] satHit;

	assign violCount = violationEvt && !(hdb3CodeWord && rxHdb3En);
	assign crcCount  = crcErrEvt && rxCrc4En && !los_q;
	assign fasCount  = fasErrEvt && !los_q;

	e1m_sat_counter u_line_violation_counter (
		.sys_clk   (sys_clk),
		.clear     (hwMode_q),
		.load      (wrOk && hit(regAddr, e1m_pkg::OFS_LINE_VIOL)),
		.loadValue (regWrData),
		.inc       (violCount),
		.count     (violCnt),
		.satHit    (satHit[0])
	);

	e1m_sat_counter u_crc_error_counter (
		.sys_clk   (sys_clk),
		.clear     (hwMode_q),
		.load      (wrOk && hit(regAddr, e1m_pkg::OFS_CRC_ERR)),
		.loadValue (regWrData),
		.inc       (crcCount),
		.count     (crcCnt),
		.satHit    (satHit[1])
	);

	e1m_sat_counter u_frame_error_counter (
		.sys_clk   (sys_clk),
		.clear     (hwMode_q),
		.load      (wrOk && hit(regAddr, e1m_pkg::OFS_FRAME_ERR)),
		.loadValue (regWrData),
		.inc       (fasCount),
		.count     (fasCnt),
		.satHit    (satHit[2])
	);

	////////////////////////////////////////////////////////////////////
	// Three-in-a-row alarm filters: 0 remote, 1 distant multiframe
	logic [1:0] almStrobe;
	logic [1:0] almBit;
	logic [1:0] almOut_q;

	assign almStrobe = {frame0Ts16Strobe, nonAlignStrobe};
	assign almBit    = {frame0Ts16Bit6, nonAlignBit3};

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_alarm
			logic [1:0] run_q;
			always_ff @(posedge sys_clk or negedge nrst) begin
				if (!nrst) begin
					run_q       <= 2'h0;
					almOut_q[g] <= 1'b0;
				end else if (almStrobe[g]) begin
					// Count samples that disagree with the output
					if (almBit[g] == almOut_q[g]) begin
						run_q <= 2'h0;
					end else if (run_q == e1m_pkg::ALARM_RUN - 2'h1) begin
						run_q       <= 2'h0;
						almOut_q[g] <= almBit[g];
					end else begin
						run_q <= run_q + 2'h1;
					end
				end
			end
		end
	endgenerate

	assign remote_alarm_out     = almOut_q[0];
	assign distant_mf_alarm_out = almOut_q[1];

	////////////////////////////////////////////////////////////////////
	// Carrier loss
	logic [5:0] zeroRun_q;
	logic       carrierLoss_q;
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			zeroRun_q     <= 6'h00;
			carrierLoss_q <= 1'b0;
		end else if (lineBitStrobe) begin
			if (posIn || negIn) begin
				zeroRun_q     <= 6'h00;
				carrierLoss_q <= 1'b0;
			end else if (zeroRun_q != e1m_pkg::ZERO_RUN) begin
				zeroRun_q <= zeroRun_q + 6'h01;
				if (zeroRun_q == e1m_pkg::ZERO_RUN - 6'h01) begin
					carrierLoss_q <= 1'b1;
				end
			end
		end
	end
	assign carrier_loss_out = carrierLoss_q;

	////////////////////////////////////////////////////////////////////
	// Violation pulse and frame error output
	logic violPulse_q;
	logic casHold_q;
	logic frameErr_q;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			violPulse_q <= 1'b0;
		end else begin
			violPulse_q <= violCount;
		end
	end
	assign violation_pulse_out = violPulse_q;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			casHold_q <= 1'b0;
		end else if (casMfErrEvt) begin
			casHold_q <= 1'b1;
		end else if (casIntervalEnd) begin
			casHold_q <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			frameErr_q <= 1'b0;
		end else begin
			frameErr_q <= fasErrEvt || crcErrEvt || casMfErrEvt ||
				(casHold_q && !casIntervalEnd);
		end
	end
	assign frame_error_out = frameErr_q;

	////////////////////////////////////////////////////////////////////
	// Receive status register and interrupt
	logic [7:0] statSet;
	logic [7:0] statActive;
	logic [7:0] status_q;

	always_comb begin
		statSet                      = 8'h00;
		statSet[e1m_pkg::STAT_RA]     = almOut_q[0];
		statSet[e1m_pkg::STAT_DMA]    = almOut_q[1];
		statSet[e1m_pkg::STAT_LOS]    = los_q;
		statSet[e1m_pkg::STAT_SAT]    = |satHit;
		statActive                    = statSet;
		statActive[e1m_pkg::STAT_SAT] = 1'b0;
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			status_q <= e1m_pkg::RST_REG;
		end else if (hwMode_q) begin
			status_q <= e1m_pkg::RST_REG;
		end else if (rdDirect) begin
			status_q <= statSet | (status_q & statActive);
		end else begin
			status_q <= statSet | status_q;
		end
	end

	assign irqOut = |(status_q & mask_q & e1m_pkg::STAT_USED);

	////////////////////////////////////////////////////////////////////
	// Read data
	logic [7:0] rdMux;
	always_comb begin
		unique case (regAddr)
			e1m_pkg::OFS_COMMON_CTRL: rdMux = commonCtrl_q;
			e1m_pkg::OFS_TX_CTRL:     rdMux = txCtrl_q;
			e1m_pkg::OFS_RX_CTRL:     rdMux = rxCtrl_q;
			e1m_pkg::OFS_TX_IDLE:     rdMux = txIdle_q;
			e1m_pkg::OFS_TX_EXTRA:    rdMux = txExtra_q;
			e1m_pkg::OFS_RX_STATUS:   rdMux = status_q & e1m_pkg::STAT_USED;
			e1m_pkg::OFS_RX_IRQ_MASK: rdMux = mask_q;
			e1m_pkg::OFS_LINE_VIOL:   rdMux = violCnt;
			e1m_pkg::OFS_CRC_ERR:     rdMux = crcCnt;
			e1m_pkg::OFS_FRAME_ERR:   rdMux = fasCnt;
			default:                  rdMux = 8'h00;
		endcase
	end

	logic [7:0] rdData_q;
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			rdData_q <= 8'h00;
		end else if (regRdEn) begin
			rdData_q <= hwMode_q ? 8'h00 : rdMux;
		end
	end
	assign regRdData = rdData_q;

endmodule // e1m_rx_alarm_monitor

`default_nettype wire

// file: verification/e1m_rx_alarm_monitor_sva.sv
// Purpose: Port assertions for the receive error and alarm monitor
// Assumes: Bound to the monitor top; one clock domain
// Notes:   Watches a subset of the top ports
`default_nettype none

module e1m_rx_alarm_monitor_sva (
	input wire logic       sys_clk,
	input wire logic       nrst,
	input wire logic       violationEvt,
	input wire logic       hdb3CodeWord,
	input wire logic       rxHdb3En,
	input wire logic       violation_pulse_out,
	input wire logic       syncSearch,
	input wire logic       loss_of_sync_out,
	input wire logic       fasErrEvt,
	input wire logic       crcErrEvt,
	input wire logic       casMfErrEvt,
	input wire logic       casIntervalEnd,
	input wire logic       frame_error_out,
	input wire logic       nonAlignStrobe,
	input wire logic       nonAlignBit3,
	input wire logic       remote_alarm_out,
	input wire logic       frame0Ts16Strobe,
	input wire logic       frame0Ts16Bit6,
	input wire logic       distant_mf_alarm_out,
	input wire logic       lineBitStrobe,
	input wire logic       carrier_loss_out,
	input wire logic       hwMode,
	input wire logic       txHdb3En,
	input wire logic       txCrc4En,
	input wire logic       rxCrc4En,
	input wire logic       txCasEn,
	input wire logic       rxCasEn,
	input wire logic       regRdEn,
	input wire logic [7:0] regRdData
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);

	////////////////////////////////////////////////////////////////////
	AST_VIOL_PULSE: assert property (
		violationEvt && !(hdb3CodeWord && rxHdb3En) |=> violation_pulse_out)
		else $error("violation pulse missing");
	AST_VIOL_SKIP: assert property (
		violationEvt && hdb3CodeWord && rxHdb3En |=> !violation_pulse_out)
		else $error("code word gave a violation pulse");
	AST_VIOL_ONE: assert property (
		!violationEvt |=> !violation_pulse_out)
		else $error("violation pulse without cause");
	AST_LOS_SET: assert property (syncSearch |=> loss_of_sync_out)
		else $error("loss of sync low during search");
	AST_LOS_FALL: assert property (
		$fell(loss_of_sync_out) |-> $past(!syncSearch))
		else $error("loss of sync fell during search");
	AST_FER_FAS: assert property (fasErrEvt |=> frame_error_out)
		else $error("frame error output missed an error");
	AST_FER_CAUSE: assert property (
		$rose(frame_error_out) |-> $past(fasErrEvt || crcErrEvt || casMfErrEvt))
		else $error("frame error output without cause");
	AST_CAS_HOLD: assert property (
		casMfErrEvt && !casIntervalEnd ##1 !casIntervalEnd[*2]
		|=> frame_error_out)
		else $error("frame error dropped inside interval");
	AST_RA_RISE: assert property (
		$rose(remote_alarm_out) |-> $past(nonAlignStrobe && nonAlignBit3))
		else $error("remote alarm rose without set bit");
	AST_DMA_RISE: assert property (
		$rose(distant_mf_alarm_out) |-> $past(frame0Ts16Strobe && frame0Ts16Bit6))
		else $error("distant alarm rose without set bit");
	AST_CL_RISE: assert property (
		$rose(carrier_loss_out) |-> $past(lineBitStrobe))
		else $error("carrier loss rose off a line bit");
	AST_HW_BOTH: assert property (
		hwMode |-> rxCasEn == txCasEn && rxHdb3En == txHdb3En
			&& rxCrc4En == txCrc4En)
		else $error("strap not applied to both directions");
	AST_HW_READ: assert property (
		hwMode && regRdEn |=> regRdData == 8'h00)
		else $error("register read in hardware mode not zero");

	cover property ($rose(remote_alarm_out));
	cover property ($rose(carrier_loss_out));
	cover property (casMfErrEvt ##1 frame_error_out[*3]);
endmodule // e1m_rx_alarm_monitor_sva

bind e1m_rx_alarm_monitor e1m_rx_alarm_monitor_sva i_sva (.*);

`default_nettype wire

// file: verification/e1m_line_model.sv
// Purpose: Receive line model, one bit every four clocks
// Assumes: Pins change two clocks before the bit strobe
// Notes:   Quiet sends zeros on both pins; else alternate marks
`default_nettype none

module e1m_line_model (
	input  wire logic sys_clk,
	input  wire logic nrst,
	input  wire logic quiet,
	output var logic  lineBitStrobe,
	output var logic  line_in_positive,
	output var logic  line_in_negative
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] ph = 2'h0;
	logic       pol = 1'b0;

	initial begin
		lineBitStrobe = 1'b0;
		line_in_positive = 1'b0;
		line_in_negative = 1'b0;
	end

	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			ph <= 2'h0;
			lineBitStrobe <= 1'b0;
		end else begin
			ph <= ph + 2'h1;
			lineBitStrobe <= (ph == 2'h1);
			if (ph == 2'h3) begin
				line_in_positive <= !quiet && !pol;
				line_in_negative <= !quiet && pol;
				pol <= pol ^ !quiet;
			end
		end
	end
endmodule // e1m_line_model

`default_nettype wire

// file: verification/e1m_rx_alarm_monitor_tb_top.sv
// Purpose: Self-checking bench for the receive error and alarm monitor
// Assumes: Event pulses held n cycles count n events
// Notes:   Reads are checked by a monitor against a queue
`default_nettype none

module e1m_rx_alarm_monitor_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk = 1'b0, nrst = 1'b0, quiet = 1'b0, serial_port_select = 1'b1;
	logic tx_remote_alarm_strap = 1'b0, tx_distant_mf_alarm_strap = 1'b0;
	logic dataFormatStrap = 1'b0, crc4Strap = 1'b0, casDisableStrap = 1'b0;
	logic hdb3CodeWord = 1'b0, syncSearch = 1'b0;
	logic nonAlignStrobe = 1'b0, nonAlignBit3 = 1'b0;
	logic frame0Ts16Strobe = 1'b0, frame0Ts16Bit6 = 1'b0;
	logic regWrEn = 1'b0, regRdEn = 1'b0, regBurst = 1'b0, rdSeen = 1'b0;
	logic [4:0] ev = 5'h00, s;
	logic [3:0] regAddr = 4'h0;
	logic [7:0] regWrData = 8'h00, regRdData, pv;
	logic [15:0] ent;
	wire logic casIntervalEnd, casMfErrEvt, fasErrEvt, crcErrEvt, violationEvt;
	logic lineBitStrobe, line_in_positive, line_in_negative, irqOut;
	logic loss_of_sync_out, remote_alarm_out, distant_mf_alarm_out;
	logic carrier_loss_out, violation_pulse_out, frame_error_out, hwMode;
	logic txRemoteAlarmEn, txDistantMfAlarmEn, txHdb3En, rxHdb3En;
	logic txCrc4En, rxCrc4En, txCasEn, rxCasEn;
	logic [15:0] expQ[$];
	int numErrors = 0, checksDone = 0;

	assign {casIntervalEnd, casMfErrEvt, fasErrEvt, crcErrEvt, violationEvt} = ev;
	e1m_rx_alarm_monitor i_e1m_rx_alarm_monitor (.*);
	e1m_line_model i_e1m_line_model (.*);
	initial forever #20 sys_clk = ~sys_clk;

	////////////////////////////////////////////////////////////////////
	task automatic give_verdict;
		$display("errors %0d checks %0d", numErrors, checksDone);
		if (numErrors == 0 && checksDone > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic fail(input string m);
		numErrors++;
		$display("wrong value at %0t: %s", $time, m);
	endtask
	task automatic chk(input logic got, input logic exp, input string m);
		checksDone++;
		if (got !== exp) fail(m);
	endtask
	task automatic tk(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	task automatic pulse(input logic [4:0] v, input int n);
		@(posedge sys_clk);
		ev <= v;
		tk(n);
		ev <= 5'h00;
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		regAddr <= a;
		regWrData <= d;
		regWrEn <= 1'b1;
		@(posedge sys_clk);
		regWrEn <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e,
			input logic [7:0] m, input logic b);
		expQ.push_back({m, e});
		@(posedge sys_clk);
		regAddr <= a;
		regBurst <= b;
		regRdEn <= 1'b1;
		@(posedge sys_clk);
		regRdEn <= 1'b0;
	endtask
	task automatic vp(input logic cw, input logic exp);
		hdb3CodeWord <= cw;
		pulse(5'h01, 1);
		#1 chk(violation_pulse_out, exp, "violation pulse");
		@(posedge sys_clk);
		#1 chk(violation_pulse_out, 1'b0, "violation pulse width");
	endtask
	task automatic bits(input int n);
		int c = 0;
		for (int i = 0; i < 8 * n && c < n; i++) begin
			@(posedge sys_clk);
			if (lineBitStrobe === 1'b1) c++;
		end
		if (c < n) begin
			fail("line strobe stalled");
			give_verdict();
		end
	endtask
	task automatic al(input logic dm, input logic [5:0] bv, input logic [5:0] ov);
		for (int i = 5; i >= 0; i--) begin
			@(posedge sys_clk);
			frame0Ts16Strobe <= dm;
			frame0Ts16Bit6 <= bv[i];
			nonAlignStrobe <= !dm;
			nonAlignBit3 <= bv[i];
			@(posedge sys_clk);
			frame0Ts16Strobe <= 1'b0;
			nonAlignStrobe <= 1'b0;
			#1 chk(dm ? distant_mf_alarm_out : remote_alarm_out, ov[i], "alarm");
		end
	endtask

	always @(posedge sys_clk) begin
		if (rdSeen) begin
			if (expQ.size() == 0) begin
				fail("unexpected read");
			end else begin
				ent = expQ.pop_front();
				checksDone++;
				if ((regRdData & ent[15:8]) !== (ent[7:0] & ent[15:8])) fail("read");
			end
		end
		rdSeen <= regRdEn;
	end

	////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(32'h8F4A));
		tk(10);
		chk(loss_of_sync_out, 1'b1, "resync in reset");
		nrst <= 1'b1;
		tk(3);
		rd(4'h5, 8'h02, 8'hFF, 1'b0);
		wr(4'h6, 8'h01);
		pv = 8'hF8 + 8'($urandom_range(0, 4));
		wr(4'h9, pv);
		pulse(5'h04, int'(8'hFF - pv) + 2);
		tk(2);
		chk(irqOut, 1'b1, "saturation interrupt");
		rd(4'h9, 8'hFF, 8'hFF, 1'b0);
		rd(4'h5, 8'h01, 8'hC3, 1'b1);
		rd(4'h5, 8'h01, 8'hC3, 1'b0);
		rd(4'h5, 8'h00, 8'h01, 1'b0);
		pulse(5'h04, 1);
		tk(2);
		chk(irqOut, 1'b1, "interrupt at saturation");
		wr(4'h6, 8'h00);
		#1 chk(irqOut, 1'b0, "masked interrupt");
		pv = 8'($urandom_range(0, 200));
		wr(4'h9, pv);
		pulse(5'h04, 1);
		rd(4'h9, pv + 8'h01, 8'hFF, 1'b0);
		wr(4'h8, 8'h00);
		wr(4'h7, 8'h00);
		pulse(5'h02, 2);
		rd(4'h8, 8'h00, 8'hFF, 1'b0);
		wr(4'h0, 8'h04);
		pulse(5'h02, 3);
		rd(4'h8, 8'h03, 8'hFF, 1'b0);
		rd(4'h9, pv + 8'h01, 8'hFF, 1'b0);
		syncSearch <= 1'b1;
		tk(2);
		#1 chk(loss_of_sync_out, 1'b1, "loss of sync");
		pulse(5'h07, 2);
		syncSearch <= 1'b0;
		rd(4'h8, 8'h03, 8'hFF, 1'b0);
		rd(4'h9, pv + 8'h01, 8'hFF, 1'b0);
		rd(4'h5, 8'h02, 8'h02, 1'b0);
		rd(4'h5, 8'h00, 8'h02, 1'b0);
		vp(1'b1, 1'b1);
		wr(4'h0, 8'h14);
		vp(1'b1, 1'b0);
		vp(1'b0, 1'b1);
		rd(4'h7, 8'h04, 8'hFF, 1'b0);
		pulse(5'h08, 1);
		tk(4);
		#1 chk(frame_error_out, 1'b1, "interval hold");
		pulse(5'h10, 1);
		tk(2);
		#1 chk(frame_error_out, 1'b0, "interval end");
		al(1'b0, 6'h37, 6'h01);
		al(1'b1, 6'h37, 6'h01);
		rd(4'h5, 8'hC0, 8'hC0, 1'b0);
		al(1'b0, 6'h08, 6'h3E);
		al(1'b1, 6'h08, 6'h3E);
		quiet <= 1'b1;
		bits(20);
		chk(carrier_loss_out, 1'b0, "early carrier loss");
		bits(20);
		chk(carrier_loss_out, 1'b1, "carrier loss");
		quiet <= 1'b0;
		bits(3);
		tk(2);
		chk(carrier_loss_out, 1'b0, "carrier back");
		pv = 8'($urandom);
		wr(4'h7, pv);
		nrst <= 1'b0;
		tk(2);
		nrst <= 1'b1;
		tk(3);
		rd(4'h7, pv, 8'hFF, 1'b0);
		rd(4'h0, 8'h00, 8'hFF, 1'b0);
		for (int k = 0; k < 3; k++) begin
			s = (k < 2) ? {5{k[0]}} : 5'($urandom);
			nrst <= 1'b0;
			serial_port_select <= 1'b0;
			{tx_remote_alarm_strap, tx_distant_mf_alarm_strap, dataFormatStrap,
				crc4Strap, casDisableStrap} <= s;
			tk(2);
			nrst <= 1'b1;
			tk(4);
			#1 chk(hwMode, 1'b1, "hardware mode");
			chk(txRemoteAlarmEn, s[4], "remote strap");
			chk(txDistantMfAlarmEn, s[3], "distant strap");
			chk(rxHdb3En, s[2], "format strap");
			chk(txCrc4En, s[1], "crc strap");
			chk(rxCasEn, !s[0], "cas strap");
			wr(4'h9, 8'h33);
			rd(4'h9, 8'h00, 8'hFF, 1'b0);
		end
		tk(4);
		if (expQ.size() != 0) fail("reads missing");
		give_verdict();
	end
endmodule // e1m_rx_alarm_monitor_tb_top

`default_nettype wire
